// *** rtl/tcd_tap.sv ***
// Test access port controller with data register scan path.
`timescale 1ns/1ps

// The controller lives in two clock domains. The state machine, the
// instruction register and the shift stages run on the test clock, which
// the tester may stop at either level for as long as it likes. The
// boundary outputs, the drive and float levels and the reset indication
// run on the system clock.

// Only levels cross between the two domains. Each one passes the
// three-stage synchroniser, and the boundary words are guarded by a
// freeze request and an update toggle instead of being carried bit by bit.

// The crossing assumes that a test clock period is longer than about six
// system clock periods. A faster test clock can load a boundary word that
// is still changing, or run past an update toggle before it is seen.

// The instruction scan is decoded only far enough to latch the current
// instruction; no further test registers hang off it.

// Functional notes
// - State advances on each rising test clock edge from the mode select level.
// - Reset lands in Test-Logic-Reset with the identification instruction current.
// - Test-Logic-Reset leaves all normal system functions running untouched.
// - Run-Test-Idle holds instruction and data registers unchanged.
// - Select-DR-Scan: low goes Capture-DR, high goes Select-IR-Scan; registers hold.
// - Capture-DR loads the selected register in parallel when it supports it.
// - Capture-DR: low goes Shift-DR, high goes Exit1-DR.
// - Shift-DR moves the selected register one bit toward serial out per edge.
// - Registers not in the serial path keep their contents during Shift-DR.
// - Exit1-DR: high goes Update-DR, low goes Pause-DR.
// - Pause-DR holds shifting; stays while low, high goes Exit2-DR.
// - Exit2-DR: high goes Update-DR, low returns to Shift-DR.
// - Update-DR copies shift stages to output latches on the falling edge.
// - Select-IR-Scan: low goes Capture-IR, high back to Test-Logic-Reset.
// - Test clock may stop high or low at any time; state is kept.
// - Capture-IR loads a fixed value; low goes Shift-IR, high Exit1-IR.
module tcd_tap #(
  parameter int              BSR_LEN  = 16,
  parameter logic [3:0]      ID_VER   = 4'h0,     // Arbitrary value.
  parameter logic [15:0]     ID_PART  = 16'h0001, // Arbitrary value.
  parameter logic [10:0]     ID_MFR   = 11'h001   // Arbitrary value.
) (
  // System clock and reset.
  input  wire logic               i_clock,
  input  wire logic               i_srst,
  // Test port pins.
  input  wire logic               i_test_clock_in,
  input  wire logic               i_test_reset_n,
  input  wire logic               i_test_mode_select_in,
  input  wire logic               i_test_serial_in,
  output logic                    o_test_serial_out,
  output logic                    o_test_serial_out_oe_n,
  // Boundary cells on the system side.
  input  wire logic [BSR_LEN-1:0] i_bsr_capture,
  output logic      [BSR_LEN-1:0] o_bsr_drive,
  output logic                    o_test_drive,
  output logic                    o_test_highz,
  output logic                    o_test_logic_reset
);

  // ---------------- Test clock domain ----------------

  tcd_pkg::tcd_state_t state;
  tcd_pkg::tcd_state_t next_state;

  logic [tcd_pkg::IR_LEN-1:0] ir_shift;
  logic [tcd_pkg::IR_LEN-1:0] ir_current;
  logic [tcd_pkg::ID_LEN-1:0] id_shift;
  logic [BSR_LEN-1:0]         bsr_shift;
  logic [BSR_LEN-1:0]         bsr_latch;
  logic                       bypass_shift;
  logic                       update_toggle;
  logic                       freeze_req;
  logic                       tdo_bit;
  logic                       tdo_oe_n;

  wire tms = i_test_mode_select_in;

  // Next state from the mode select level. Every state has exactly two
  // successors, so one select level per rising edge walks the diagram.
  // The instruction column is kept complete so the machine stays in step
  // with the tester, although only its capture value, its shifting and its
  // update matter to the rest of the block.
  always_comb begin
    next_state = state;
    unique case (state)
      // Reset, idle and the data register column.
      tcd_pkg::ST_TEST_LOGIC_RESET:
        next_state = tms ? tcd_pkg::ST_TEST_LOGIC_RESET
                         : tcd_pkg::ST_RUN_TEST_IDLE;
      tcd_pkg::ST_RUN_TEST_IDLE:
        next_state = tms ? tcd_pkg::ST_SELECT_DR
                         : tcd_pkg::ST_RUN_TEST_IDLE;
      tcd_pkg::ST_SELECT_DR:
        next_state = tms ? tcd_pkg::ST_SELECT_IR
                         : tcd_pkg::ST_CAPTURE_DR;
      tcd_pkg::ST_CAPTURE_DR:
        next_state = tms ? tcd_pkg::ST_EXIT1_DR
                         : tcd_pkg::ST_SHIFT_DR;
      tcd_pkg::ST_SHIFT_DR:
        next_state = tms ? tcd_pkg::ST_EXIT1_DR
                         : tcd_pkg::ST_SHIFT_DR;
      tcd_pkg::ST_EXIT1_DR:
        next_state = tms ? tcd_pkg::ST_UPDATE_DR
                         : tcd_pkg::ST_PAUSE_DR;
      tcd_pkg::ST_PAUSE_DR:
        next_state = tms ? tcd_pkg::ST_EXIT2_DR
                         : tcd_pkg::ST_PAUSE_DR;
      tcd_pkg::ST_EXIT2_DR:
        next_state = tms ? tcd_pkg::ST_UPDATE_DR
                         : tcd_pkg::ST_SHIFT_DR;
      tcd_pkg::ST_UPDATE_DR:
        next_state = tms ? tcd_pkg::ST_SELECT_DR
                         : tcd_pkg::ST_RUN_TEST_IDLE;
      // Instruction register column.
      tcd_pkg::ST_SELECT_IR:
        next_state = tms ? tcd_pkg::ST_TEST_LOGIC_RESET
                         : tcd_pkg::ST_CAPTURE_IR;
      tcd_pkg::ST_CAPTURE_IR:
        next_state = tms ? tcd_pkg::ST_EXIT1_IR
                         : tcd_pkg::ST_SHIFT_IR;
      tcd_pkg::ST_SHIFT_IR:
        next_state = tms ? tcd_pkg::ST_EXIT1_IR
                         : tcd_pkg::ST_SHIFT_IR;
      tcd_pkg::ST_EXIT1_IR:
        next_state = tms ? tcd_pkg::ST_UPDATE_IR
                         : tcd_pkg::ST_PAUSE_IR;
      tcd_pkg::ST_PAUSE_IR:
        next_state = tms ? tcd_pkg::ST_EXIT2_IR
                         : tcd_pkg::ST_PAUSE_IR;
      tcd_pkg::ST_EXIT2_IR:
        next_state = tms ? tcd_pkg::ST_UPDATE_IR
                         : tcd_pkg::ST_SHIFT_IR;
      tcd_pkg::ST_UPDATE_IR:
        next_state = tms ? tcd_pkg::ST_SELECT_DR
                         : tcd_pkg::ST_RUN_TEST_IDLE;
    endcase
  end

  // Five rising edges with select high reach Test-Logic-Reset from any state.
  // The test reset acts at once and needs no clock edge, since the tester
  // may hold the clock still while it pulls the reset low. Between edges
  // the state simply stands, whichever level the clock rests at.
  always_ff @(posedge i_test_clock_in or negedge i_test_reset_n) begin
    if (!i_test_reset_n) begin
      state <= tcd_pkg::ST_TEST_LOGIC_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Decoding of the current instruction and the state.
  wire in_cap_dr   = (state == tcd_pkg::ST_CAPTURE_DR);
  wire in_shift_dr = (state == tcd_pkg::ST_SHIFT_DR);
  wire in_cap_ir   = (state == tcd_pkg::ST_CAPTURE_IR);
  wire in_shift_ir = (state == tcd_pkg::ST_SHIFT_IR);
  wire in_tlr      = (state == tcd_pkg::ST_TEST_LOGIC_RESET);
  // Codes that select neither the boundary register nor the identification
  // register fall through to bypass, so every such code, even an unused one,
  // leaves a one-bit path between serial in and serial out.
  wire sel_bsr     = (ir_current == tcd_pkg::IR_EXTEST) ||
                     (ir_current == tcd_pkg::IR_SAMPLE);
  wire sel_id      = (ir_current == tcd_pkg::IR_IDCODE);
  wire sel_bypass  = !sel_bsr && !sel_id;
  wire drive_mode  = (ir_current == tcd_pkg::IR_EXTEST) ||
                     (ir_current == tcd_pkg::IR_CLAMP);
  wire highz_mode  = (ir_current == tcd_pkg::IR_HIGHZ);
  // The marker bit sits lowest, so it is the first bit that leaves the
  // identification register after a capture.
  wire [tcd_pkg::ID_LEN-1:0] id_value =
    {ID_VER, ID_PART, ID_MFR, tcd_pkg::ID_MARKER};
  // The freeze request rises on the edge that enters Select-DR-Scan and
  // falls on the edge that leaves Capture-DR, so the snapshot already
  // stands still a full test clock period before it is loaded.
  wire next_freeze = (next_state == tcd_pkg::ST_SELECT_DR) ||
                     (next_state == tcd_pkg::ST_CAPTURE_DR);
  wire dr_out_bit  = sel_bsr ? bsr_shift[0] :
                     sel_id  ? id_shift[0]  : bypass_shift;
  wire serial_bit  = in_shift_ir ? ir_shift[0] : dr_out_bit;
  wire shifting    = in_shift_dr || in_shift_ir;

  logic [BSR_LEN-1:0] snap;

  // Instruction shift stage.
  // The fixed capture value ends in a one, so a chain that is stuck at
  // either level shows up on the very first instruction scan.
  always_ff @(posedge i_test_clock_in or negedge i_test_reset_n) begin
    if (!i_test_reset_n) begin
      ir_shift <= tcd_pkg::IR_CAPTURE;
    end else if (in_cap_ir) begin
      ir_shift <= tcd_pkg::IR_CAPTURE;
    end else if (in_shift_ir) begin
      ir_shift <= {i_test_serial_in, ir_shift[tcd_pkg::IR_LEN-1:1]};
    end
  end

  // Data registers change only in Capture-DR or Shift-DR when selected.
  // Every other state, Run-Test-Idle and Pause-DR among them, leaves them
  // untouched, and a register off the serial path never moves.
  always_ff @(posedge i_test_clock_in or negedge i_test_reset_n) begin
    if (!i_test_reset_n) begin
      id_shift     <= '0;
      bsr_shift    <= '0;
      bypass_shift <= tcd_pkg::BYPASS_CAPTURE;
      freeze_req   <= 1'b0;
    end else begin
      freeze_req <= next_freeze;
      if (in_cap_dr) begin
        if (sel_id) begin
          id_shift <= id_value;
        end
        if (sel_bsr) begin
          bsr_shift <= snap;
        end
        if (sel_bypass) begin
          bypass_shift <= tcd_pkg::BYPASS_CAPTURE;
        end
      end else if (in_shift_dr) begin
        if (sel_id) begin
          id_shift <= {i_test_serial_in, id_shift[tcd_pkg::ID_LEN-1:1]};
        end
        if (sel_bsr) begin
          bsr_shift <= {i_test_serial_in, bsr_shift[BSR_LEN-1:1]};
        end
        if (sel_bypass) begin
          bypass_shift <= i_test_serial_in;
        end
      end
    end
  end

  // Falling-edge logic: instruction latch, output latches and serial out.
  // Serial out changes half a period before the tester samples it, which
  // gives the far side the whole low phase as setup time. The enable takes
  // the same edge, so the pin is driven from the first falling edge inside a shift state to the first falling edge after it.
  // A new instruction is current from the first rising edge after
  // Update-IR, because the latch takes the falling edge inside that state.
  always_ff @(negedge i_test_clock_in or negedge i_test_reset_n) begin
    if (!i_test_reset_n) begin
      ir_current    <= tcd_pkg::IR_IDCODE;
      bsr_latch     <= '0;
      update_toggle <= 1'b0;
      tdo_bit       <= tcd_pkg::TDO_RESET;
      tdo_oe_n      <= tcd_pkg::OE_N_RESET;
    end else begin
      if (in_tlr) begin
        ir_current <= tcd_pkg::IR_IDCODE;
      end else if (state == tcd_pkg::ST_UPDATE_IR) begin
        ir_current <= ir_shift;
      end
      if (state == tcd_pkg::ST_UPDATE_DR && sel_bsr) begin
        bsr_latch     <= bsr_shift;
        update_toggle <= !update_toggle;
      end
      tdo_bit  <= shifting ? serial_bit : tcd_pkg::TDO_RESET;
      tdo_oe_n <= !shifting;
    end
  end

  // The pin driver takes both straight from their flip-flops.
  assign o_test_serial_out      = tdo_bit;
  assign o_test_serial_out_oe_n = tdo_oe_n;

  // ---------------- System clock domain ----------------

  // Levels and the update toggle cross through the synchroniser.
  // The reset indication travels inverted, so the cleared synchroniser
  // matches the reset value of the output and no false low pulse follows
  // a system reset. Each carried bit changes at most once per test clock
  // period, so the bits are filtered independently without gray coding.
  logic [tcd_pkg::XS_W-1:0] xs_async;
  logic [tcd_pkg::XS_W-1:0] xs_sync;
  logic                     toggle_seen;
  logic                     drive_lvl;
  logic                     highz_lvl;
  logic                     tlr_lvl;

  // Drive and float levels are forced off in Test-Logic-Reset, so normal
  // system functions run untouched there whatever the last instruction was.
  always_ff @(negedge i_test_clock_in or negedge i_test_reset_n) begin
    if (!i_test_reset_n) begin
      drive_lvl <= 1'b0;
      highz_lvl <= 1'b0;
      tlr_lvl   <= 1'b1;
    end else begin
      drive_lvl <= drive_mode && !in_tlr;
      highz_lvl <= highz_mode && !in_tlr;
      tlr_lvl   <= in_tlr;
    end
  end

  always_comb begin
    xs_async                    = '0;
    xs_async[tcd_pkg::XS_TLR]    = !tlr_lvl;
    xs_async[tcd_pkg::XS_DRIVE]  = drive_lvl;
    xs_async[tcd_pkg::XS_HIGHZ]  = highz_lvl;
    xs_async[tcd_pkg::XS_TOGGLE] = update_toggle;
    xs_async[tcd_pkg::XS_FREEZE] = freeze_req;
  end

  // One synchroniser carries every level; only the system reset clears it.
  tcd_sync #(
    .WIDTH (tcd_pkg::XS_W)
  ) u_sync (
    .i_clock (i_clock),
    .i_srst  (i_srst),
    .i_async (xs_async),
    .o_sync  (xs_sync)
  );

  // A change of the synchronised toggle marks a finished Update-DR; the
  // boundary latch has stood still since that edge and is copied whole.
  wire frozen     = xs_sync[tcd_pkg::XS_FREEZE];
  wire new_update = xs_sync[tcd_pkg::XS_TOGGLE] != toggle_seen;

  // The snapshot stands still while the controller heads into Capture-DR,
  // so the test clock side reads a stable word.
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      snap               <= '0;
      toggle_seen        <= 1'b0;
      o_bsr_drive        <= '0;
      o_test_drive       <= 1'b0;
      o_test_highz       <= 1'b0;
      o_test_logic_reset <= 1'b1;
    end else begin
      if (!frozen) begin
        snap <= i_bsr_capture;
      end
      toggle_seen <= xs_sync[tcd_pkg::XS_TOGGLE];
      if (new_update) begin
        o_bsr_drive <= bsr_latch;
      end
      o_test_drive       <= xs_sync[tcd_pkg::XS_DRIVE];
      o_test_highz       <= xs_sync[tcd_pkg::XS_HIGHZ];
      o_test_logic_reset <= !xs_sync[tcd_pkg::XS_TLR];
    end
  end

endmodule : tcd_tap

// *** rtl/tcd_pkg.sv ***
// Shared constants and types for the test access port controller.
package tcd_pkg;

  // Controller states; Test-Logic-Reset is the state after reset.
  typedef enum logic [3:0] {
    ST_TEST_LOGIC_RESET,
    ST_RUN_TEST_IDLE,
    ST_SELECT_DR,
    ST_CAPTURE_DR,
    ST_SHIFT_DR,
    ST_EXIT1_DR,
    ST_PAUSE_DR,
    ST_EXIT2_DR,
    ST_UPDATE_DR,
    ST_SELECT_IR,
    ST_CAPTURE_IR,
    ST_SHIFT_IR,
    ST_EXIT1_IR,
    ST_PAUSE_IR,
    ST_EXIT2_IR,
    ST_UPDATE_IR
  } tcd_state_t;

  // Instruction register layout and codes.
  localparam int          IR_LEN        = 3;
  localparam logic [2:0]  IR_EXTEST     = 3'h0;
  localparam logic [2:0]  IR_IDCODE     = 3'h1;
  localparam logic [2:0]  IR_SAMPLE     = 3'h2;
  localparam logic [2:0]  IR_CLAMP      = 3'h3;
  localparam logic [2:0]  IR_HIGHZ      = 3'h4;
  localparam logic [2:0]  IR_BYPASS     = 3'h7;
  localparam logic [2:0]  IR_CAPTURE    = 3'h1;

  // Identification register field layout.
  localparam int          ID_LEN        = 32;
  localparam int          ID_VER_LSB    = 28;
  localparam int          ID_VER_W      = 4;
  localparam int          ID_PART_LSB   = 12;
  localparam int          ID_PART_W     = 16;
  localparam int          ID_MFR_LSB    = 1;
  localparam int          ID_MFR_W      = 11;
  localparam logic        ID_MARKER     = 1'b1;

  // Reset values.
  localparam logic        BYPASS_CAPTURE = 1'b0;
  localparam logic        TDO_RESET      = 1'b0;
  localparam logic        OE_N_RESET     = 1'b1;

  // Positions of the levels carried from the test clock to the system clock.
  localparam int          XS_TLR        = 0;
  localparam int          XS_DRIVE      = 1;
  localparam int          XS_HIGHZ      = 2;
  localparam int          XS_TOGGLE     = 3;
  localparam int          XS_FREEZE     = 4;
  localparam int          XS_W          = 5;

  // Synchroniser depth for inputs from another clock.
  localparam int          SYNC_STAGES   = 3;

endpackage : tcd_pkg

// *** rtl/tcd_sync.sv ***
// Three-stage synchroniser for independent level signals.
`timescale 1ns/1ps
module tcd_sync #(
  parameter int WIDTH = 1
) (
  // System clock and reset.
  input  wire logic             i_clock,
  input  wire logic             i_srst,
  // Asynchronous levels in, filtered levels out.
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // A bit changes at the output only once stages two and three agree.
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      always_ff @(posedge i_clock) begin
        if (i_srst) begin
          stage1[b] <= 1'b0;
          stage2[b] <= 1'b0;
          stage3[b] <= 1'b0;
          o_sync[b] <= 1'b0;
        end else begin
          stage1[b] <= i_async[b];
          stage2[b] <= stage1[b];
          stage3[b] <= stage2[b];
          if (stage2[b] == stage3[b]) begin
            o_sync[b] <= stage3[b];
          end
        end
      end
    end
  endgenerate

endmodule : tcd_sync

// *** sim/tcd_tap_props.sv ***
// Concurrent checks on the pins of the test access port controller.
`timescale 1ns/1ps
module tcd_tap_props #(
  parameter int BSR_LEN = 16
) (
  // System clock, reset and test port inputs.
  input wire logic               i_clock,
  input wire logic               i_srst,
  input wire logic               i_test_clock_in,
  input wire logic               i_test_reset_n,
  // Controller outputs.
  input wire logic               o_test_serial_out,
  input wire logic               o_test_serial_out_oe_n,
  input wire logic [BSR_LEN-1:0] o_bsr_drive,
  input wire logic               o_test_drive,
  input wire logic               o_test_highz,
  input wire logic               o_test_logic_reset
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_srst);
  sequence s_reset_held;
    !i_test_reset_n [*7];
  endsequence
  sequence s_tlr_held;
    o_test_logic_reset [*3];
  endsequence
  a_oe_test_reset: assert property (
    !i_test_reset_n |-> o_test_serial_out_oe_n)
    else $error("Serial out enabled during test reset.");
  a_out_idle_low: assert property (
    o_test_serial_out_oe_n |-> !o_test_serial_out)
    else $error("Serial out not low while released.");
  a_oe_on_fall: assert property (
    $changed(o_test_serial_out_oe_n) |-> !i_test_clock_in)
    else $error("Output enable moved while test clock high.");
  a_out_on_fall: assert property (
    $changed(o_test_serial_out) |-> !i_test_clock_in)
    else $error("Serial out moved while test clock high.");
  a_tlr_on_reset: assert property (
    s_reset_held |-> o_test_logic_reset)
    else $error("Test reset did not reach the reset state.");
  a_drive_off_tlr: assert property (
    s_tlr_held |-> !o_test_drive)
    else $error("Pins driven by test logic in the reset state.");
  a_highz_off_tlr: assert property (
    s_tlr_held |-> !o_test_highz)
    else $error("Pins floated by test logic in the reset state.");
  a_bsr_on_fall: assert property (
    $changed(o_bsr_drive) |-> !i_test_clock_in)
    else $error("Boundary outputs moved while test clock high.");
endmodule : tcd_tap_props

// *** sim/tcd_tester.sv ***
// Behavioural external test controller driving the test port pins.
`timescale 1ns/1ps
module tcd_tester (
  // Test port pins toward the device.
  output logic o_test_clock_in,
  output logic o_test_reset_n,
  output logic o_test_mode_select_in,
  output logic o_test_serial_in
);
  // Reset starts released, so the first pulse gives a real falling edge.
  initial begin
    o_test_clock_in = 1'b0;
    o_test_reset_n = 1'b1;
    o_test_mode_select_in = 1'b1;
    o_test_serial_in = 1'b0;
  end
  // The clock rests low between calls; hold_ns keeps it stopped high.
  task automatic tick(input logic sel, input logic din, input int hold_ns);
    o_test_mode_select_in = sel;
    o_test_serial_in = din;
    #80 o_test_clock_in = 1'b1;
    #(80 + hold_ns) o_test_clock_in = 1'b0;
  endtask : tick
  task automatic pulse_reset();
    o_test_reset_n = 1'b0;
    #200 o_test_reset_n = 1'b1;
  endtask : pulse_reset
endmodule : tcd_tester

// *** sim/tcd_tap_test.sv ***
// Self-checking bench for the test access port controller.
`timescale 1ns/1ps
module tcd_tap_test;
  localparam int          BSR_LEN = 16;
  localparam logic [3:0]  VER     = 4'hA;     // Arbitrary value.
  localparam logic [15:0] PART    = 16'h5A3C; // Arbitrary value.
  localparam logic [10:0] MFR     = 11'h2B7;  // Arbitrary value.
  localparam logic [31:0] ID      = {VER, PART, MFR, 1'b1};
  logic                   clock, srst, tck, trst_n, tms, tdi, tdo, oe_n;
  logic                   t_drive, t_highz, t_tlr;
  logic [BSR_LEN-1:0]     cap, bsr, bsr_exp;
  logic [31:0]            din;
  integer                 seed = 32'h93AF0505;
  int                     n_mismatch = 0;
  int                     check_count = 0;
  logic                   exp_q[$];

  tcd_tap #(.BSR_LEN(BSR_LEN), .ID_VER(VER), .ID_PART(PART),
            .ID_MFR(MFR)) i_dut (
    .i_clock(clock), .i_srst(srst), .i_test_clock_in(tck),
    .i_test_reset_n(trst_n), .i_test_mode_select_in(tms),
    .i_test_serial_in(tdi), .o_test_serial_out(tdo),
    .o_test_serial_out_oe_n(oe_n), .i_bsr_capture(cap),
    .o_bsr_drive(bsr), .o_test_drive(t_drive), .o_test_highz(t_highz),
    .o_test_logic_reset(t_tlr));
  tcd_tester u_tester (.o_test_clock_in(tck), .o_test_reset_n(trst_n),
    .o_test_mode_select_in(tms), .o_test_serial_in(tdi));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task automatic settle();
    repeat (8) @(posedge clock);
    #1;
  endtask : settle

  // Select levels are taken least significant bit first.
  task automatic walk(input logic [7:0] sels, input int n);
    for (int i = 0; i < n; i++) u_tester.tick(sels[i], 1'b0, 0);
  endtask : walk

  // The second bit of every burst stops the clock high for a while.
  task automatic shift(input int n, input logic [31:0] d, e);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(e[i]);
      u_tester.tick(i == n - 1, d[i], i == 1 ? 400 : 0);
    end
  endtask : shift

  task automatic ir_scan(input logic [2:0] code);
    walk(8'h03, 4);
    shift(3, {29'h0, code}, 32'h1);
    walk(8'h01, 2);
    settle();
  endtask : ir_scan

  // Each data scan pauses halfway and resumes through the second exit.
  task automatic dr_scan(input int n, input logic [31:0] e);
    walk(8'h01, 3);
    shift(n / 2, din, e);
    walk(8'h04, 4);
    shift(n - n / 2, din >> (n / 2), e >> (n / 2));
    walk(8'h01, 2);
    settle();
  endtask : dr_scan

  always @(posedge tck) begin
    if (oe_n === 1'b0) begin
      check("tdo", tdo, exp_q.size() > 0 ? exp_q.pop_front() : 1'bx);
    end
  end

  initial begin
    #200_000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    srst = 1'b1;
    cap = '0;
    bsr_exp = '0;
    din = $random(seed);
    repeat (10) @(posedge clock);
    #1 srst = 1'b0;
    u_tester.pulse_reset();
    settle();
    check("tlr", t_tlr, 1'b1);
    walk(8'h00, 1);
    settle();
    check("tlr", t_tlr, 1'b0);
    dr_scan(32, ID);
    for (int c = 7; c >= 0; c--) begin
      cap = BSR_LEN'($random(seed));
      din = $random(seed);
      ir_scan(3'(c));
      check("drive", t_drive, c == 0 || c == 3);
      check("highz", t_highz, c == 4);
      if (c == 1) begin
        dr_scan(32, ID);
      end else if (c == 0 || c == 2) begin
        dr_scan(BSR_LEN, 32'(cap));
        bsr_exp = din[BSR_LEN-1:0];
      end else begin
        dr_scan(4, {din[28:0], 3'h0} >> 2);
      end
      check("bsr", bsr, 32'(bsr_exp));
    end
    walk(8'h1F, 5);
    settle();
    check("tlr", t_tlr, 1'b1);
    check("drive", t_drive, 1'b0);
    walk(8'h00, 1);
    walk(8'h01, 3);
    #1;
    check("oe_n", oe_n, 1'b0);
    u_tester.pulse_reset();
    check("oe_n", oe_n, 1'b1);
    settle();
    check("tlr", t_tlr, 1'b1);
    walk(8'h00, 1);
    walk(8'h35, 7);
    dr_scan(32, ID);
    check("queue", exp_q.size(), 32'h0);
    print_verdict();
  end
endmodule : tcd_tap_test

bind tcd_tap tcd_tap_props #(.BSR_LEN(BSR_LEN)) u_props (
  .i_clock(i_clock), .i_srst(i_srst), .i_test_clock_in(i_test_clock_in),
  .i_test_reset_n(i_test_reset_n), .o_test_serial_out(o_test_serial_out),
  .o_test_serial_out_oe_n(o_test_serial_out_oe_n),
  .o_bsr_drive(o_bsr_drive), .o_test_drive(o_test_drive),
  .o_test_highz(o_test_highz), .o_test_logic_reset(o_test_logic_reset));
